// >>> rtl/bit_store.sv
`default_nettype none
module bit_store (
    input wire logic clk, // system clock
    input wire logic wr_en, // one-cycle write strobe
    input wire logic [14:0] wr_idx, // word index to write
    input wire logic [31:0] wr_word, // word to store
    input wire logic [14:0] stream_idx, // word under the bit counter
    output logic [31:0] stream_word, // async read for streaming
    input wire logic [14:0] sw_idx, // word index for software
    output logic [31:0] sw_word // async read for software
);
    // nonvolatile array; no reset, contents survive device resets
    logic [31:0] mem [cfg_loader_pkg::MEM_WORDS];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_word;
        end
    end

    // async read so bit zero is on the pin before the first edge
    assign stream_word = mem[stream_idx];
    assign sw_word = mem[sw_idx];
endmodule : bit_store
`default_nettype wire

// >>> rtl/cfg_loader_pkg.sv
`default_nettype none
package cfg_loader_pkg;
    // stream geometry for both capacity variants
    localparam int ADDR_W = 21;
    localparam int IDX_W = 15;
    localparam int MEM_WORDS = 32768;
    localparam logic [20:0] CAP_512K = 21'h8_0000;
    localparam logic [20:0] CAP_1M = 21'h10_0000;
    localparam logic [4:0] TRAIL_CLOCKS = 5'h10;
    // timing: system clock, oscillator and power-on reset
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_PERIOD_NS = 400;
    localparam int POR_TIME_NS = 2000;
    localparam int OSC_HALF_CYC = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int POR_CYC = POR_TIME_NS / CLK_PERIOD_NS;
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_POLARITY = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_BIT_ADDR = 8'h0c;
    localparam logic [7:0] REG_MEM_INDEX = 8'h10;
    localparam logic [7:0] REG_MEM_DATA = 8'h14;
    // field positions and reset values
    localparam int CTRL_CAP_1M_BIT = 0;
    localparam logic CTRL_RESET = 1'b1;
    localparam logic [31:0] POL_ACTIVE_HIGH_CODE = 32'h0000_0000;
    localparam logic [31:0] POL_RESET = 32'hffff_ffff;
    localparam logic [14:0] PROT_WORDS = 15'h0400;

    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_HOLD = 3'b001,
        ST_RUN = 3'b010,
        ST_TRAIL = 3'b011,
        ST_IDLE = 3'b100,
        ST_PROG = 3'b101
    } state_type;

    // protected portion sits at the bottom of the array
    function automatic logic is_protected(input logic [14:0] idx);
        return idx < PROT_WORDS;
    endfunction : is_protected
endpackage : cfg_loader_pkg
`default_nettype wire

// >>> rtl/pin_sync.sv
`default_nettype none
module pin_sync #(
    parameter int W = 5
) (
    input wire logic clk, // system clock
    input wire logic reset, // async, active high
    input wire logic [W-1:0] async_in, // raw pins
    output logic [W-1:0] sync_out // two-flop synchronised
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // first stage feeds only the second stage
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : pin_sync
`default_nettype wire

// >>> rtl/serial_config_readout.sv
`default_nettype none
// Behaviour
// - reset level on oe/reset clears bit counter and floats data
// - chain_select_n high after reset pulse: counter halted, data floated
// - chain_select_n low, reset inactive: counter counts, data driven
// - any new reset level clears counter, floats data, whatever chain_select_n
// - all bits sent and cascade low: data floats for next memory
// - counter cleared at power-up with no pin action
// - ready pulled low during power-on reset, released afterwards
// - stream stored bits serially, timed by internal oscillator
// - master (reset with chain_select_n low) makes every clock pulse
// - master asserts cascade_out_n low after its last bit
// - master keeps clocking downstream memories until transfer ends
// - done raises chain_select_n: 16 more clocks, then idle; code does so only once the master's stream is exhausted, else standby
// - reset polarity chosen by four nonvolatile bytes
// - load_mode_select low enters programming mode
// - chain_select_n high: standby, data floated regardless of oe
// - write_protect_in blocks writes to protected memory portion
// - counter spans 512K or 1M bits
// - rising clock edge advances counter only when enabled; idle clock low
// - cascade_out_n low when counter reaches maximum
// - reset with select low makes master; high makes subsequent
module serial_config_readout (
    input wire logic clk, // 20 MHz system clock
    input wire logic reset, // async power-on reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic oe_reset_in, // output enable / reset pin
    input wire logic chain_select_n, // chip select, active low
    input wire logic load_mode_select, // low selects programming mode
    input wire logic write_protect_in, // protects low memory
    input wire logic cfg_bit_clock_in, // clock pin level
    output logic cfg_bit_clock_out, // clock drive value
    output logic cfg_bit_clock_oe, // high while driving clock
    output logic data_out, // serial data drive value
    output logic data_oe, // high while driving data
    output logic cascade_out_n, // cascade select, active low
    output logic ready_out, // open-collector ready, drives low
    output logic ready_oe // high while ready pulled low
);
    logic [4:0] pins_sync;
    logic s_oe, s_cs_n, s_lms, s_clk, s_wp;
    logic clk_d_r, clk_d_nxt, link_rise, osc_rise, bit_edge, rst_act, osc_en;
    cfg_loader_pkg::state_type state_r, state_nxt;
    logic [20:0] addr_r, addr_nxt, cap;
    logic exh_r, exh_nxt, master_r, master_nxt;
    logic [4:0] trail_r, trail_nxt;
    logic [7:0] por_r, por_nxt;
    logic [2:0] osc_cnt_r, osc_cnt_nxt;
    logic osc_r, osc_nxt;
    logic data_r, data_nxt, doe_r, doe_nxt, casc_r, casc_nxt;
    logic clk_oe_r, clk_oe_nxt, rdy_oe_r, rdy_oe_nxt;
    logic ctrl_r, ctrl_nxt;
    logic [31:0] pol_r, pol_nxt, prdata_r, prdata_nxt, stream_word, sw_word;
    logic pready_r, pready_nxt, perr_r, perr_nxt, mem_we;
    logic [14:0] midx_r, midx_nxt;

    pin_sync #(.W(5)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({write_protect_in, cfg_bit_clock_in, load_mode_select,
                   chain_select_n, oe_reset_in}),
        .sync_out(pins_sync)
    );
    assign {s_wp, s_clk, s_lms, s_cs_n, s_oe} = pins_sync;

    bit_store u_store (
        .clk(clk),
        .wr_en(mem_we),
        .wr_idx(midx_r),
        .wr_word(pwdata),
        .stream_idx(addr_nxt[19:5]), // next word, so bit 32 is not read from word 0
        .stream_word(stream_word),
        .sw_idx(midx_r),
        .sw_word(sw_word)
    );

    // polarity from the four nonvolatile bytes; default is reset active low
    assign rst_act = (pol_r == cfg_loader_pkg::POL_ACTIVE_HIGH_CODE) ? s_oe : ~s_oe;
    assign cap = ctrl_r ? cfg_loader_pkg::CAP_1M : cfg_loader_pkg::CAP_512K;
    assign link_rise = s_clk & ~clk_d_r;
    assign osc_rise = osc_en && !osc_r && osc_cnt_r == 3'(cfg_loader_pkg::OSC_HALF_CYC - 1);
    // subsequent device counts on the master's edges only while selected
    assign bit_edge = master_r ? osc_rise : (link_rise & ~s_cs_n);
    // master clocks its own stream, downstream memories and the trailer
    assign osc_en = master_r && ((state_r == cfg_loader_pkg::ST_RUN && !s_cs_n && !rst_act)
                    || state_r == cfg_loader_pkg::ST_TRAIL);

    // readout sequencer
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        exh_nxt = exh_r;
        master_nxt = master_r;
        trail_nxt = trail_r;
        por_nxt = por_r;
        clk_d_nxt = s_clk;
        case (state_r)
            cfg_loader_pkg::ST_POR: begin
                addr_nxt = '0;
                por_nxt = por_r + 8'h01;
                if (por_r == 8'(cfg_loader_pkg::POR_CYC - 1)) begin
                    state_nxt = cfg_loader_pkg::ST_HOLD;
                    master_nxt = ~s_cs_n;
                end
            end
            cfg_loader_pkg::ST_PROG: begin
                addr_nxt = '0;
                exh_nxt = 1'b0;
                if (s_lms) begin
                    state_nxt = cfg_loader_pkg::ST_HOLD;
                end
            end
            cfg_loader_pkg::ST_HOLD: begin
                // standby keeps the count; only a reset level or programming mode clears it
                if (!s_cs_n) begin
                    state_nxt = cfg_loader_pkg::ST_RUN;
                end
            end
            cfg_loader_pkg::ST_RUN: begin
                if (s_cs_n) begin
                    // select rising early is the fpga's error to flag
                    state_nxt = (master_r && exh_r) ? cfg_loader_pkg::ST_TRAIL
                                                    : cfg_loader_pkg::ST_HOLD;
                    trail_nxt = '0;
                end else if (bit_edge && !exh_r) begin
                    addr_nxt = addr_r + 21'h1;
                    exh_nxt = (addr_nxt == cap);
                end
            end
            cfg_loader_pkg::ST_TRAIL: begin
                if (osc_rise) begin
                    trail_nxt = trail_r + 5'h01;
                    if (trail_nxt == cfg_loader_pkg::TRAIL_CLOCKS) begin
                        state_nxt = cfg_loader_pkg::ST_IDLE;
                    end
                end
            end
            cfg_loader_pkg::ST_IDLE: begin
                state_nxt = cfg_loader_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = cfg_loader_pkg::ST_HOLD;
            end
        endcase
        if (state_r != cfg_loader_pkg::ST_POR) begin
            if (!s_lms) begin
                state_nxt = cfg_loader_pkg::ST_PROG;
                addr_nxt = '0;
                exh_nxt = 1'b0;
            end else if (rst_act) begin
                // reset level overrides all but programming mode, chain role re-latched
                state_nxt = cfg_loader_pkg::ST_HOLD;
                addr_nxt = '0;
                exh_nxt = 1'b0;
                master_nxt = ~s_cs_n;
            end
        end
    end

    // oscillator divider; idles low so the master holds the clock low
    always_comb begin
        osc_cnt_nxt = '0;
        osc_nxt = 1'b0;
        if (osc_en) begin
            osc_cnt_nxt = osc_cnt_r + 3'h1;
            osc_nxt = osc_r;
            if (osc_cnt_r == 3'(cfg_loader_pkg::OSC_HALF_CYC - 1)) begin
                osc_cnt_nxt = '0;
                osc_nxt = ~osc_r;
            end
        end
    end

    // pin outputs, all registered from next-state values
    always_comb begin
        data_nxt = stream_word[addr_nxt[4:0]];
        doe_nxt = state_nxt == cfg_loader_pkg::ST_RUN && !s_cs_n && !exh_nxt
                  && !rst_act && s_lms;
        casc_nxt = ~exh_nxt;
        clk_oe_nxt = master_nxt && state_nxt != cfg_loader_pkg::ST_POR
                     && state_nxt != cfg_loader_pkg::ST_PROG;
        rdy_oe_nxt = state_nxt == cfg_loader_pkg::ST_POR;
    end

    // apb slave: decode in setup, answer with pready in the access cycle
    always_comb begin
        ctrl_nxt = ctrl_r;
        pol_nxt = pol_r;
        midx_nxt = midx_r;
        mem_we = 1'b0;
        pready_nxt = psel && !penable;
        perr_nxt = 1'b0;
        prdata_nxt = '0;
        if (psel && !penable) begin
            case (paddr)
                cfg_loader_pkg::REG_CTRL: prdata_nxt = {31'h0, ctrl_r};
                cfg_loader_pkg::REG_POLARITY: prdata_nxt = pol_r;
                cfg_loader_pkg::REG_STATUS:
                    prdata_nxt = {24'h0, rdy_oe_r, exh_r, master_r, 2'h0, state_r};
                cfg_loader_pkg::REG_BIT_ADDR: prdata_nxt = {11'h0, addr_r};
                cfg_loader_pkg::REG_MEM_INDEX: prdata_nxt = {17'h0, midx_r};
                cfg_loader_pkg::REG_MEM_DATA: begin
                    prdata_nxt = sw_word;
                    // writes only in programming mode and outside protection
                    perr_nxt = pwrite && (state_r != cfg_loader_pkg::ST_PROG
                               || (s_wp && cfg_loader_pkg::is_protected(midx_r)));
                end
                default: perr_nxt = 1'b1;
            endcase
        end
        if (psel && penable && pready_r && pwrite && !perr_r) begin
            case (paddr)
                cfg_loader_pkg::REG_CTRL: ctrl_nxt = pwdata[cfg_loader_pkg::CTRL_CAP_1M_BIT];
                cfg_loader_pkg::REG_POLARITY: pol_nxt = pwdata;
                cfg_loader_pkg::REG_MEM_INDEX: midx_nxt = pwdata[14:0];
                cfg_loader_pkg::REG_MEM_DATA: begin
                    mem_we = 1'b1;
                    midx_nxt = midx_r + 15'h1;
                end
                default: mem_we = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= cfg_loader_pkg::ST_POR;
            addr_r <= '0;
            exh_r <= 1'b0;
            master_r <= 1'b0;
            trail_r <= '0;
            por_r <= '0;
            clk_d_r <= 1'b0;
            osc_cnt_r <= '0;
            osc_r <= 1'b0;
            data_r <= 1'b0;
            doe_r <= 1'b0;
            casc_r <= 1'b1;
            clk_oe_r <= 1'b0;
            rdy_oe_r <= 1'b1;
            ctrl_r <= cfg_loader_pkg::CTRL_RESET;
            pol_r <= cfg_loader_pkg::POL_RESET;
            midx_r <= '0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            perr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            exh_r <= exh_nxt;
            master_r <= master_nxt;
            trail_r <= trail_nxt;
            por_r <= por_nxt;
            clk_d_r <= clk_d_nxt;
            osc_cnt_r <= osc_cnt_nxt;
            osc_r <= osc_nxt;
            data_r <= data_nxt;
            doe_r <= doe_nxt;
            casc_r <= casc_nxt;
            clk_oe_r <= clk_oe_nxt;
            rdy_oe_r <= rdy_oe_nxt;
            ctrl_r <= ctrl_nxt;
            pol_r <= pol_nxt;
            midx_r <= midx_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            perr_r <= perr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = perr_r;
    assign cfg_bit_clock_out = osc_r;
    assign cfg_bit_clock_oe = clk_oe_r;
    assign data_out = data_r;
    assign data_oe = doe_r;
    assign cascade_out_n = casc_r;
    assign ready_out = 1'b0;
    assign ready_oe = rdy_oe_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_RESET_CLEARS: assert property (
        (rst_act && s_lms && state_r != cfg_loader_pkg::ST_POR)
        |=> (addr_r == 21'h0 && !data_oe))
        else $error("reset level did not clear counter and float data");
    AST_HOLD_HALTS: assert property (
        (state_r == cfg_loader_pkg::ST_HOLD && s_cs_n && !rst_act && s_lms)
        |=> ($stable(addr_r) && !data_oe))
        else $error("counter moved or data driven in hold");
    AST_RUN_DRIVES: assert property (
        (state_r == cfg_loader_pkg::ST_RUN && !s_cs_n && !rst_act && s_lms && !exh_r && !bit_edge)
        |=> data_oe)
        else $error("data not driven while selected and enabled");
    AST_STANDBY_FLOAT: assert property (
        s_cs_n |=> !data_oe)
        else $error("data driven while deselected");
    AST_CASC_FLOAT: assert property (
        !cascade_out_n |-> !data_oe)
        else $error("data driven after stream exhausted");
    AST_CASC_AT_MAX: assert property (
        $rose(exh_r) |-> (addr_r == cap) ##1 !cascade_out_n)
        else $error("cascade not tied to counter maximum");
    AST_READY_POR: assert property (
        $fell(ready_oe) |-> $past(por_r) == 8'(cfg_loader_pkg::POR_CYC - 1))
        else $error("ready released at wrong time");
    AST_TRAIL_END: assert property (
        (state_r == cfg_loader_pkg::ST_TRAIL && trail_r == 5'h0f && osc_rise && s_lms && !rst_act)
        |=> state_r == cfg_loader_pkg::ST_IDLE ##1 !cfg_bit_clock_out)
        else $error("trailer did not end after sixteen clocks");
    AST_SUB_NO_DRIVE: assert property (
        !master_r |-> !cfg_bit_clock_oe)
        else $error("subsequent device drives clock");
    AST_PROG_ENTRY: assert property (
        (!s_lms && state_r != cfg_loader_pkg::ST_POR) |=> state_r == cfg_loader_pkg::ST_PROG)
        else $error("programming mode not entered");
    AST_WP_BLOCK: assert property (
        (mem_we && s_wp) |-> !cfg_loader_pkg::is_protected(midx_r) || !$past(s_wp))
        else $error("write reached protected memory");
    COV_TRAIL_DONE: cover property (
        state_r == cfg_loader_pkg::ST_TRAIL ##1 state_r == cfg_loader_pkg::ST_IDLE);
    COV_CASCADE: cover property ($fell(cascade_out_n));
    COV_PROG_WRITE: cover property (mem_we);
endmodule : serial_config_readout
`default_nettype wire

// >>> test/fpga_port_model.sv
`default_nettype none
module fpga_port_model (
    input wire logic clk, // system clock
    input wire logic reset, // async, active high
    input wire logic bit_clock, // clock pin level
    input wire logic serial_data, // data pin level
    input wire logic done_req, // bench asks for done
    output logic fpga_done_flag, // raises the memory's select
    output logic [31:0] bits_r, // newest bit at the top
    output logic [15:0] rises_r // clock rises seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_q;
    logic data_q;
    logic [31:0] bits_nxt;
    logic [15:0] rises_nxt;
    // the bit taken is the one shown before the rise, as the fpga samples it
    always_comb begin
        bits_nxt = bits_r;
        rises_nxt = rises_r;
        if (bit_clock && !clk_q) begin
            bits_nxt = {data_q, bits_r[31:1]};
            rises_nxt = rises_r + 16'h0001;
        end
    end
    // done comes from the bench so early and late raises can both be made
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_q <= 1'b0;
            data_q <= 1'b0;
            bits_r <= 32'h0000_0000;
            rises_r <= 16'h0000;
            fpga_done_flag <= 1'b0;
        end else begin
            clk_q <= bit_clock;
            data_q <= serial_data;
            bits_r <= bits_nxt;
            rises_r <= rises_nxt;
            fpga_done_flag <= done_req;
        end
    end
endmodule : fpga_port_model
`default_nettype wire

// >>> test/serial_config_memory_readout_test.sv
`default_nettype none
module serial_config_memory_readout_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] W0 = 32'hc3a5_0f96;
    localparam logic [31:0] W1 = 32'h5e21_b74d;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, bits_r;
    logic pready, pslverr, cfg_bit_clock_out, cfg_bit_clock_oe, data_out, data_oe;
    logic cascade_out_n, ready_out, ready_oe, fpga_done_flag, chain_select_n;
    logic oe_reset_in = 1'b1, load_mode_select = 1'b0, write_protect_in = 1'b0;
    logic ext_clk = 1'b0, done_req = 1'b0, data_last = 1'b0;
    logic cfg_bit_clock_in, data_pin;
    logic [15:0] rises_r, held_rises;
    int mismatches = 0, check_count = 0;

    // a released data pin shows the inverse of its last level, never a stale copy
    assign cfg_bit_clock_in = cfg_bit_clock_oe ? cfg_bit_clock_out : ext_clk;
    assign data_pin = data_oe ? data_out : ~data_last;
    assign chain_select_n = fpga_done_flag;
    always @(posedge clk) if (data_oe === 1'b1) data_last <= data_out;

    initial begin
        forever #25 clk = ~clk;
    end

    serial_config_readout u_serial_config_readout (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oe_reset_in(oe_reset_in), .chain_select_n(chain_select_n),
        .load_mode_select(load_mode_select), .write_protect_in(write_protect_in),
        .cfg_bit_clock_in(cfg_bit_clock_in), .cfg_bit_clock_out(cfg_bit_clock_out),
        .cfg_bit_clock_oe(cfg_bit_clock_oe), .data_out(data_out), .data_oe(data_oe),
        .cascade_out_n(cascade_out_n), .ready_out(ready_out), .ready_oe(ready_oe)
    );

    fpga_port_model u_fpga_port_model (
        .clk(clk), .reset(reset), .bit_clock(cfg_bit_clock_in), .serial_data(data_pin),
        .done_req(done_req), .fpga_done_flag(fpga_done_flag), .bits_r(bits_r),
        .rises_r(rises_r)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic give_up();
        mismatches++;
        $display("[FAIL] %0t: wait timed out", $time);
        conclude();
    endtask : give_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; an edge passes after release so calls may follow at once
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            input logic [31:0] exp_rd, input logic exp_err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n >= 20) give_up();
        if (!wr) check(prdata, exp_rd);
        check({31'h0, pslverr}, {31'h0, exp_err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : acc

    // 0: data_oe, 1: ready_oe, 2: clock rises seen by the fpga
    task automatic wait_until(input int sel, input logic [15:0] val);
        int n;
        for (n = 0; n < 3000; n++) begin
            if (sel == 0 && data_oe === val[0]) return;
            if (sel == 1 && ready_oe === val[0]) return;
            if (sel == 2 && rises_r === val) return;
            @(posedge clk);
        end
        give_up();
    endtask : wait_until

    // power-up, memory load, master stream, then a subsequent device
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check({31'h0, ready_oe}, 32'h0000_0001);
        check({31'h0, ready_out}, 32'h0);
        repeat (30) @(posedge clk);
        check({31'h0, ready_oe}, 32'h0000_0001);
        wait_until(1, 16'h0000);
        acc(1'b0, cfg_loader_pkg::REG_BIT_ADDR, 32'h0, 32'h0, 1'b0);
        acc(1'b0, cfg_loader_pkg::REG_CTRL, 32'h0, 32'h0000_0001, 1'b0);
        acc(1'b0, cfg_loader_pkg::REG_POLARITY, 32'h0, 32'hffff_ffff, 1'b0);
        acc(1'b0, cfg_loader_pkg::REG_STATUS, 32'h0, 32'h0000_0025, 1'b0);
        acc(1'b1, cfg_loader_pkg::REG_CTRL, 32'h0, 32'h0, 1'b0);
        acc(1'b0, cfg_loader_pkg::REG_CTRL, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
        write_protect_in <= 1'b1;
        repeat (4) @(posedge clk);
        acc(1'b1, cfg_loader_pkg::REG_MEM_INDEX, 32'h0, 32'h0, 1'b0);
        acc(1'b1, cfg_loader_pkg::REG_MEM_DATA, W1, 32'h0, 1'b1);
        write_protect_in <= 1'b0;
        repeat (4) @(posedge clk);
        acc(1'b1, cfg_loader_pkg::REG_MEM_DATA, W0, 32'h0, 1'b0);
        acc(1'b1, cfg_loader_pkg::REG_MEM_DATA, W1, 32'h0, 1'b0);
        acc(1'b0, cfg_loader_pkg::REG_MEM_INDEX, 32'h0, 32'h0000_0002, 1'b0);
        acc(1'b1, cfg_loader_pkg::REG_MEM_INDEX, 32'h0, 32'h0, 1'b0);
        acc(1'b0, cfg_loader_pkg::REG_MEM_DATA, 32'h0, W0, 1'b0);
        // leave programming mode and pulse the pin reset with select low
        load_mode_select <= 1'b1;
        oe_reset_in <= 1'b0;
        repeat (6) @(posedge clk);
        oe_reset_in <= 1'b1;
        wait_until(0, 16'h0001);
        check({31'h0, data_out}, {31'h0, W0[0]});
        check({16'h0, rises_r}, 32'h0);
        check({31'h0, cfg_bit_clock_oe}, 32'h0000_0001);
        wait_until(2, 16'h0020);
        check(bits_r, W0);
        wait_until(2, 16'h0040);
        check(bits_r, W1);
        check({31'h0, cascade_out_n}, 32'h0000_0001);
        acc(1'b0, cfg_loader_pkg::REG_BIT_ADDR, 32'h0, 32'h0000_0040, 1'b0);
        acc(1'b1, cfg_loader_pkg::REG_MEM_DATA, W1, 32'h0, 1'b1);
        // early done: the memory stops in standby with the count held
        done_req <= 1'b1;
        wait_until(0, 16'h0000);
        repeat (12) @(posedge clk);
        held_rises = rises_r;
        repeat (24) @(posedge clk);
        check({16'h0, rises_r}, {16'h0, held_rises});
        check({31'h0, cfg_bit_clock_out}, 32'h0);
        acc(1'b0, cfg_loader_pkg::REG_BIT_ADDR, 32'h0, {16'h0, held_rises}, 1'b0);
        oe_reset_in <= 1'b0;
        repeat (6) @(posedge clk);
        acc(1'b0, cfg_loader_pkg::REG_BIT_ADDR, 32'h0, 32'h0, 1'b0);
        check({31'h0, data_oe}, 32'h0);
        // reset taken with select high: subsequent device, reset now active high
        acc(1'b1, cfg_loader_pkg::REG_POLARITY, 32'h0, 32'h0, 1'b0);
        done_req <= 1'b0;
        wait_until(0, 16'h0001);
        check({31'h0, cfg_bit_clock_oe}, 32'h0);
        check({31'h0, data_out}, {31'h0, W0[0]});
        repeat (8) @(posedge clk);
        repeat (8) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        acc(1'b0, cfg_loader_pkg::REG_BIT_ADDR, 32'h0, 32'h0000_0008, 1'b0);
        check({24'h0, bits_r[31:24]}, {24'h0, W0[7:0]});
        acc(1'b0, cfg_loader_pkg::REG_STATUS, 32'h0, 32'h0000_0002, 1'b0);
        oe_reset_in <= 1'b1;
        wait_until(0, 16'h0000);
        acc(1'b0, cfg_loader_pkg::REG_BIT_ADDR, 32'h0, 32'h0, 1'b0);
        conclude();
    end
endmodule : serial_config_memory_readout_test
`default_nettype wire
